// File: include/smm_consts.svh
/*
 holds the offsets, field positions, reset values and address constants of the smm ram
 access control block; assumes a byte-wide configuration space and 32-bit host addresses.
*/
`ifndef SMM_CONSTS_SVH
`define SMM_CONSTS_SVH
`define SMM_OFF_CTRL 8'h9d
`define SMM_OFF_EXT 8'h9e
`define SMM_CTRL_RST 8'h02
`define SMM_EXT_RST 8'h38
`define SMM_BIT_OPEN 6
`define SMM_BIT_CLS 5
`define SMM_BIT_LCK 4
`define SMM_BIT_GEN 3
`define SMM_BIT_HEN 7
`define SMM_BIT_ERR 6
`define SMM_BIT_TEN 0
`define SMM_BASE_SEG 3'h2
`define SMM_CACHE_BITS 3'h7
`define SMM_SZ_512K 2'h2
`define SMM_SZ_1M 2'h3
`define SMM_TSEG_512K 32'h0008_0000
`define SMM_TSEG_1M 32'h0010_0000
`define SMM_COMPAT_BASE 32'h000a_0000
`define SMM_HIGH_BASE 32'hfeda_0000
`endif

// File: include/smm_pkg.sv
/*
 holds the types of the smm ram access control block; assumes nothing of its surroundings.
*/
package smm_pkg;
    // where a decoded host request goes
    typedef enum logic [1:0]
    {
        SMM_ROUTE_PASS = 2'b00,
        SMM_ROUTE_DRAM = 2'b01,
        SMM_ROUTE_HUB = 2'b10
    } smm_route_e;
endpackage

// File: hdl/smm_ram_access_control.sv
/*
 holds the smm ram control registers and the smm window decoder of the memory hub.
 assumes byte-wide configuration writes and reads on a single clock, and host requests
 that carry an smm flag and a code-fetch flag and are decoded one per cycle.
*/
// Overview of operation
// - open, close, lock need global enable set
// - open and unlocked shows compat and high smm dram, never top segment
// - close blocks compat data, allows code fetches
// - lock clears open, freezes enable fields
// - lock set by write, cleared by reset
// - global enable maps compat 128k window
// - base segment reads 010, misses pass through, refusals go hub
// - high window remaps onto compat dram
// - non-smm extended access sets error flag unless open
// - error flag cleared by writing one
// - cache indication bits always read one
// - size field picks 512k or 1m
// - top segment only for smm requests
// - top segment needs global and segment enable
`timescale 1ns/100ps
`include "smm_consts.svh"
module smm_ram_access_control
    import smm_pkg::*;
(
    input wire logic clk, // core clock, 20 mhz
    input wire logic sys_rst, // full reset, asynchronous, active high
    input wire logic cfg_wr, // configuration write strobe
    input wire logic cfg_rd, // configuration read strobe
    input wire logic [7:0] cfg_addr, // configuration byte offset
    input wire logic [7:0] cfg_wdata, // configuration write data
    output logic [7:0] cfg_rdata, // configuration read data, registered
    output logic cfg_rvalid, // read data valid, one cycle after cfg_rd
    input wire logic [31:0] top_of_usable_dram, // first address above usable dram
    input wire logic req_valid, // host request present
    input wire logic [31:0] req_addr, // host request address
    input wire logic req_smm, // request carries smm decode
    input wire logic req_code, // request is a code fetch
    output logic resp_valid, // decode result valid
    output logic [1:0] resp_route, // decode result route
    output logic [31:0] resp_addr // dram address for the request
);
    // control register fields
    logic open, closed, locked, gen;
    // extended control register fields
    logic hen, err, ten;
    logic [1:0] tseg_size;
    // next values of the control state
    logic next_open, next_closed, next_locked, next_gen;
    logic next_hen, next_err, next_ten;
    logic [1:0] next_tseg_size;
    logic [7:0] next_cfg_rdata;
    logic next_cfg_rvalid;
    // decode state
    logic next_resp_valid;
    logic [1:0] next_resp_route;
    logic [31:0] next_resp_addr;
    // combinational decode terms
    logic in_compat, in_high, in_tseg, tseg_on, high_on, bad_access;
    logic [31:0] tseg_len, tseg_base;
    logic wr_ctrl, wr_ext;
    logic [7:0] ctrl_view, ext_view;
    // compat window base, sliced for the high window remap
    logic [31:0] compat_base;

    // true when addr sits in the 128k window starting at base
    function automatic logic in_win128(input logic [31:0] addr, input logic [31:0] base);
        in_win128 = (addr[31:17] == base[31:17]);
    endfunction

    assign wr_ctrl = cfg_wr && (cfg_addr == `SMM_OFF_CTRL);
    assign wr_ext = cfg_wr && (cfg_addr == `SMM_OFF_EXT);
    // held in a signal so that its upper bits can be selected by width
    assign compat_base = `SMM_COMPAT_BASE;
    // readback images of the two registers
    assign ctrl_view = {1'b0, open, closed, locked, gen, `SMM_BASE_SEG};
    assign ext_view = {hen, err, `SMM_CACHE_BITS, tseg_size, ten};

    // window decode of the host request
    always_comb
    begin
        // segment length from the size field, zero for reserved codes
        case (tseg_size)
            `SMM_SZ_512K: tseg_len = `SMM_TSEG_512K;
            `SMM_SZ_1M: tseg_len = `SMM_TSEG_1M;
            default: tseg_len = 32'h0000_0000;
        endcase
        tseg_base = top_of_usable_dram - tseg_len;
        tseg_on = gen && ten && (tseg_len != 32'h0000_0000);
        high_on = gen && hen;
        in_compat = in_win128(req_addr, `SMM_COMPAT_BASE);
        in_high = in_win128(req_addr, `SMM_HIGH_BASE);
        in_tseg = tseg_on && (req_addr >= tseg_base) && (req_addr < top_of_usable_dram);
        // non-smm touch of an enabled extended range with the space shut
        bad_access = req_valid && !req_smm && !open
            && ((high_on && in_high) || in_tseg);
    end

    // next values of the registers and the readback
    always_comb
    begin
        next_open = open;
        next_closed = closed;
        next_locked = locked;
        next_gen = gen;
        next_hen = hen;
        next_ten = ten;
        next_tseg_size = tseg_size;
        next_err = err;
        next_cfg_rvalid = cfg_rd;
        next_cfg_rdata = cfg_rdata;
        // control register write
        if (wr_ctrl)
        begin
            if (!locked)
            begin
                // frozen once locked
                next_gen = cfg_wdata[`SMM_BIT_GEN];
            end
            // open, close and lock act only with the enable set, as written or as frozen by lock
            if (next_gen)
            begin
                next_closed = cfg_wdata[`SMM_BIT_CLS];
                if (!locked)
                begin
                    next_open = cfg_wdata[`SMM_BIT_OPEN];
                    next_locked = cfg_wdata[`SMM_BIT_LCK];
                end
            end
        end
        // extended register write
        if (wr_ext)
        begin
            if (!locked)
            begin
                next_hen = cfg_wdata[`SMM_BIT_HEN];
                next_tseg_size = cfg_wdata[2:1];
                next_ten = cfg_wdata[`SMM_BIT_TEN];
            end
            // write one to clear
            if (cfg_wdata[`SMM_BIT_ERR])
            begin
                next_err = 1'b0;
            end
        end
        // a new error wins over a clear in the same cycle
        if (bad_access)
        begin
            next_err = 1'b1;
        end
        // lock forces the open bit off
        if (next_locked)
        begin
            next_open = 1'b0;
        end
        // read data, unmapped offsets read zero
        if (cfg_rd)
        begin
            case (cfg_addr)
                `SMM_OFF_CTRL: next_cfg_rdata = ctrl_view;
                `SMM_OFF_EXT: next_cfg_rdata = ext_view;
                default: next_cfg_rdata = 8'h00;
            endcase
        end
    end

    // register the control state
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            open <= 1'b0;
            closed <= 1'b0;
            locked <= 1'b0;
            gen <= 1'b0;
            hen <= 1'b0;
            err <= 1'b0;
            ten <= 1'b0;
            tseg_size <= 2'h0;
            cfg_rdata <= 8'h00;
            cfg_rvalid <= 1'b0;
        end
        else
        begin
            open <= next_open;
            closed <= next_closed;
            locked <= next_locked;
            gen <= next_gen;
            hen <= next_hen;
            err <= next_err;
            ten <= next_ten;
            tseg_size <= next_tseg_size;
            cfg_rdata <= next_cfg_rdata;
            cfg_rvalid <= next_cfg_rvalid;
        end
    end

    // routing decision for the request
    always_comb
    begin
        next_resp_valid = req_valid;
        next_resp_route = SMM_ROUTE_PASS;
        next_resp_addr = req_addr;
        if (req_valid)
        begin
            if (in_tseg)
            begin
                // only smm requests reach the top segment
                next_resp_route = req_smm ? SMM_ROUTE_DRAM : SMM_ROUTE_HUB;
            end
            else if (in_high && high_on)
            begin
                // high window folds onto the compat dram
                next_resp_route = (req_smm || (open && !locked)) ? SMM_ROUTE_DRAM
                    : SMM_ROUTE_HUB;
                next_resp_addr = {compat_base[31:17], req_addr[16:0]};
            end
            else if (in_compat)
            begin
                // visible in smm unless a closed data reference, or when opened
                if (gen && ((req_smm && !(closed && !req_code)) || (open && !locked)))
                begin
                    next_resp_route = SMM_ROUTE_DRAM;
                end
                else
                begin
                    next_resp_route = SMM_ROUTE_HUB;
                end
            end
        end
    end

    // register the decode result
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            resp_valid <= 1'b0;
            resp_route <= SMM_ROUTE_PASS;
            resp_addr <= 32'h0000_0000;
        end
        else
        begin
            resp_valid <= next_resp_valid;
            resp_route <= next_resp_route;
            resp_addr <= next_resp_addr;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // a non-smm request into an enabled extended window with the space shut
    sequence s_bad_req;
        req_valid && !req_smm && !open && ((high_on && in_high) || in_tseg);
    endsequence
    // an smm request into the enabled high window
    sequence s_high_req;
        req_valid && req_smm && high_on && in_high && !in_tseg;
    endsequence

    a_lock_sticky: assert property (locked |=> locked)
        else $error("lock bit dropped without reset");
    a_lock_open: assert property (locked |-> !open)
        else $error("open bit set while locked");
    a_lock_frozen: assert property (locked && wr_ext |=> $stable({hen, tseg_size, ten}))
        else $error("extended field changed while locked");
    // a write without the enable leaves open, close and lock as they were
    a_need_gen: assert property (wr_ctrl && !cfg_wdata[`SMM_BIT_GEN] && !locked
        |=> $stable(open) && !locked && $stable(closed))
        else $error("open close lock acted without global enable");
    a_ctrl_read: assert property (cfg_rd && cfg_addr == `SMM_OFF_CTRL
        |=> cfg_rvalid && cfg_rdata[2:0] == 3'h2 && !cfg_rdata[7])
        else $error("control readback fixed bits wrong");
    a_ext_read: assert property (cfg_rd && cfg_addr == `SMM_OFF_EXT
        |=> cfg_rdata[5:3] == 3'h7)
        else $error("cache indication bits not one");
    a_err_set: assert property (s_bad_req |=> err ##1 (err || !$past(wr_ext)))
        else $error("invalid access not flagged");
    a_err_hold: assert property (err && !(wr_ext && cfg_wdata[`SMM_BIT_ERR]) |=> err)
        else $error("error flag lost without a write of one");
    // a write of one clears the flag when no new error competes
    a_err_clear: assert property (wr_ext && cfg_wdata[`SMM_BIT_ERR] && !bad_access
        |=> !err)
        else $error("error flag not cleared by a write of one");
    a_high_remap: assert property (s_high_req
        |=> resp_valid && resp_route == SMM_ROUTE_DRAM
        && resp_addr[31:17] == 15'h0005 && resp_addr[16:0] == $past(req_addr[16:0]))
        else $error("high window not remapped to compat dram");
    a_close_data: assert property (req_valid && req_smm && !req_code && closed
        && in_compat && !in_tseg && !(in_high && high_on) && !(open && !locked)
        |=> resp_route == SMM_ROUTE_HUB)
        else $error("closed compat space served a data reference");
    a_open_shows: assert property (req_valid && !req_smm && gen && open && !locked
        && in_compat && !in_tseg |=> resp_route == SMM_ROUTE_DRAM)
        else $error("open compat space not visible");
    a_tseg_smm: assert property (req_valid && in_tseg
        |=> resp_route == ($past(req_smm) ? SMM_ROUTE_DRAM : SMM_ROUTE_HUB))
        else $error("top segment routing wrong");
    // without the global enable the compat window goes to the hub
    a_gen_compat: assert property (req_valid && !gen && in_compat
        |=> resp_route == SMM_ROUTE_HUB)
        else $error("compat window served without global enable");
endmodule

// File: verif/smm_host_model.sv
/*
 host processor bus model: issues one request per go pulse, one cycle long.
 assumes go and its fields are driven by the bench just after a rising edge.
*/
`timescale 1ns/100ps
module smm_host_model
(
    input wire logic clk,
    input wire logic go,
    input wire logic [31:0] a,
    input wire logic s,
    input wire logic c,
    output logic req_valid = 1'b0,
    output logic [31:0] req_addr = 32'h0,
    output logic req_smm = 1'b0,
    output logic req_code = 1'b0
);
    // idle fields flip every cycle so a stale value never passes for a live one
    always @(posedge clk)
    begin
        req_valid <= go;
        req_addr <= go ? a : ~req_addr;
        req_smm <= go ? s : ~req_smm; // smm indication travels with the request
        req_code <= go ? c : ~req_code;
    end
endmodule

// File: verif/smm_ram_access_control_tb.sv
/*
 self-checking bench: config reads and host requests note expected results in queues.
 assumes the package, the design and the host model are compiled first.
*/
`timescale 1ns/100ps
module smm_ram_access_control_tb;
    import smm_pkg::*;
    logic clk = 0, sys_rst = 1, cfg_wr = 0, cfg_rd = 0, go = 0, h_s = 0, h_c = 0;
    logic [7:0] cfg_addr = 8'h0, cfg_wdata = 8'h0, cfg_rdata;
    logic [31:0] t = 32'h1000_0000, h_a = 32'h0, o = 32'h0, req_addr, resp_addr;
    logic cfg_rvalid, req_valid, req_smm, req_code, resp_valid;
    logic [1:0] resp_route;
    logic [7:0] qc[$];
    logic [33:0] qr[$];
    int n_mismatch = 0, n_checks = 0, seed = 8;
    smm_host_model u_host (.clk(clk), .go(go), .a(h_a), .s(h_s), .c(h_c), .req_valid(req_valid),
        .req_addr(req_addr), .req_smm(req_smm), .req_code(req_code));
    smm_ram_access_control u_dut (.clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .top_of_usable_dram(t), .req_valid(req_valid),
        .req_addr(req_addr), .req_smm(req_smm), .req_code(req_code), .resp_valid(resp_valid),
        .resp_route(resp_route), .resp_addr(resp_addr));
    // 20 mhz core clock
    initial
    begin
        forever #25 clk = ~clk;
    end
    // one comparison, counted
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // one config write
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_addr <= ad;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask
    // one config read, expected byte noted
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clk);
        cfg_rd <= 1'b1;
        cfg_addr <= ad;
        qc.push_back(e);
        @(posedge clk);
        cfg_rd <= 1'b0;
    endtask
    // one host request, expected route and address noted
    task automatic rq(input logic [31:0] a, input logic s, input logic c,
        input smm_route_e r, input logic [31:0] ea);
        @(posedge clk);
        go <= 1'b1;
        h_a <= a;
        h_s <= s;
        h_c <= c;
        qr.push_back({r, ea});
        @(posedge clk);
        go <= 1'b0;
    endtask
    // monitor: oldest note against each result
    always @(posedge clk)
    begin
        if (cfg_rvalid === 1'b1)
            chk("cfg_rdata", {26'h0, cfg_rdata}, {26'h0, qc.pop_front()});
        if (resp_valid === 1'b1)
            chk("resp", {resp_route, resp_addr}, qr.pop_front());
    end
    // watchdog
    initial
    begin
        repeat (4000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
    // main sequence
    initial
    begin
        t = t + ({$random(seed)} & 32'h0ff0_0000);
        o = {$random(seed)} & 32'h0001_ffff;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h9d, 8'h02);
        rd(8'h9e, 8'h38);
        rd(8'h9f, 8'h00);
        wr(8'h9d, 8'h40);
        rd(8'h9d, 8'h02);
        wr(8'h9d, 8'hc8);
        rd(8'h9d, 8'h4a);
        wr(8'h9e, 8'h85);
        rd(8'h9e, 8'hbd);
        rq(32'ha0000 + o, 0, 0, SMM_ROUTE_DRAM, 32'ha0000 + o);
        rq(32'hfeda0000 + o, 0, 0, SMM_ROUTE_DRAM, 32'ha0000 + o);
        rq(t - 32'h80000 + o, 0, 0, SMM_ROUTE_HUB, t - 32'h80000 + o);
        rd(8'h9e, 8'hbd);
        wr(8'h9d, 8'h08);
        rq(32'ha0000 + o, 0, 1, SMM_ROUTE_HUB, 32'ha0000 + o);
        rq(32'hfeda0000 + o, 1, 0, SMM_ROUTE_DRAM, 32'ha0000 + o);
        rq(32'hfeda0000 + o, 0, 0, SMM_ROUTE_HUB, 32'ha0000 + o);
        rd(8'h9e, 8'hfd);
        wr(8'h9e, 8'h85);
        rd(8'h9e, 8'hfd);
        wr(8'h9e, 8'hc5);
        rd(8'h9e, 8'hbd);
        wr(8'h9d, 8'h28);
        rq(32'ha0000 + o, 1, 0, SMM_ROUTE_HUB, 32'ha0000 + o);
        rq(32'ha0000 + o, 1, 1, SMM_ROUTE_DRAM, 32'ha0000 + o);
        rq(32'hfeda0000 + o, 1, 0, SMM_ROUTE_DRAM, 32'ha0000 + o);
        rq(t - 32'h80000, 1, 0, SMM_ROUTE_DRAM, t - 32'h80000);
        rq(t - 32'h80001, 1, 0, SMM_ROUTE_PASS, t - 32'h80001);
        rq(t, 1, 0, SMM_ROUTE_PASS, t);
        wr(8'h9e, 8'h87);
        rq(t - 32'h100000, 1, 0, SMM_ROUTE_DRAM, t - 32'h100000);
        wr(8'h9e, 8'h86);
        rq(t - 32'h100000, 1, 0, SMM_ROUTE_PASS, t - 32'h100000);
        wr(8'h9d, 8'h00);
        rq(32'hfeda0000 + o, 1, 0, SMM_ROUTE_PASS, 32'hfeda0000 + o);
        // open first, then closed again before locking
        wr(8'h9d, 8'h48);
        wr(8'h9d, 8'h08);
        wr(8'h9d, 8'h18);
        rd(8'h9d, 8'h1a);
        wr(8'h9d, 8'h48);
        rd(8'h9d, 8'h1a);
        wr(8'h9d, 8'h08);
        rd(8'h9d, 8'h1a);
        repeat (4) wr(8'h9e, 8'($random(seed)));
        rd(8'h9e, 8'hbe);
        rq(32'ha0000 + o, 0, 0, SMM_ROUTE_HUB, 32'ha0000 + o);
        repeat (3) @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h9d, 8'h02);
        repeat (4) @(posedge clk);
        chk("pending notes", 34'(qc.size() + qr.size()), 34'h0);
        end_sim();
    end
endmodule
